//--- design/hscr_consts.vh
// hscr_consts.vh: constants for the hypervisor system control register block
// assumes: included by bare name from design files, definitions only
`ifndef HSCR_CONSTS_VH
`define HSCR_CONSTS_VH

// coprocessor transfer selector for this register
`define HSCR_CP_NUM        4'hF
`define HSCR_OPC1          3'h4
`define HSCR_CRN           4'h1
`define HSCR_CRM           4'h0
`define HSCR_OPC2          3'h0

// processor mode encodings
`define HSCR_MODE_HYP      5'h1A
`define HSCR_MODE_MON      5'h16

// field positions
`define HSCR_BIT_EXC_ISET     30
`define HSCR_BIT_BYTE_ORDER   25
`define HSCR_BIT_LOW_LAT_IRQ  21
`define HSCR_BIT_WR_NO_EXEC   19
`define HSCR_BIT_I         12
`define HSCR_BIT_C         2
`define HSCR_BIT_A         1
`define HSCR_BIT_M         0

// bits that software may change
`define HSCR_WR_MASK       32'h42081007
// reserved bits that read as one
`define HSCR_RAO_MASK      32'h30C50878
// reset value of writable fields
`define HSCR_RESET_VAL     32'h00000000
// reset value of the read data register
`define HSCR_RDATA_RESET   32'h00000000
// reset value of the captured exception byte order
`define HSCR_EXC_E_RESET   1'b0

`endif

//--- design/hscr_access_check.v
// hscr_access_check.v: decides whether a coprocessor transfer targets this
// register and whether the current mode may perform it
// assumes: mode and world flag are valid in the same cycle as the request
`timescale 1ns/100ps
`default_nettype none
`include "hscr_consts.vh"

module hscr_access_check (
   input  wire [3:0] cp_num,
   input  wire [2:0] cp_opc1,
   input  wire [3:0] cp_crn,
   input  wire [3:0] cp_crm,
   input  wire [2:0] cp_opc2,
   input  wire [4:0] cur_mode,
   input  wire       world_select_flag,
   output wire       sel_hit,
   output wire       mode_ok
);

   // address decode of the coprocessor selector
   assign sel_hit = (cp_num == `HSCR_CP_NUM) && (cp_opc1 == `HSCR_OPC1) &&
                    (cp_crn == `HSCR_CRN) && (cp_crm == `HSCR_CRM) &&
                    (cp_opc2 == `HSCR_OPC2);

   // hypervisor mode, or monitor mode in the non-secure world
   assign mode_ok = (cur_mode == `HSCR_MODE_HYP) ||
                    ((cur_mode == `HSCR_MODE_MON) && world_select_flag);

endmodule
`default_nettype wire

//--- design/hscr_top.v
// hscr_top.v: hypervisor system control register with its control outputs
// assumes: single clock, requests synchronous, one transfer per cycle at most
//
// What this block does
// - Access allowed only in hypervisor mode, or monitor mode with non-secure flag.
// - Bit 30 picks instruction state for exceptions taken to hypervisor mode.
// - Exception entry loads program status endianness from bit 25.
// - Hypervisor table walks use byte order from bit 25.
// - Bit 21 unimplemented: reads zero, writes ignored.
// - Bit 19 set forces writable hypervisor translations to execute-never.
// - Bit 12 enables instruction caching for hypervisor accesses.
// - Bit 2 enables data and unified caches for hypervisor accesses.
// - Bit 1 enables alignment fault checking for hypervisor accesses.
// - Bit 0 enables stage-1 translation for hypervisor accesses.
`timescale 1ns/100ps
`default_nettype none
`include "hscr_consts.vh"

module hscr_top (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        clk_en,
   input  wire        cp_valid,
   input  wire        cp_write,
   input  wire [3:0]  cp_num,
   input  wire [2:0]  cp_opc1,
   input  wire [3:0]  cp_crn,
   input  wire [3:0]  cp_crm,
   input  wire [2:0]  cp_opc2,
   input  wire [31:0] cp_wdata,
   input  wire [4:0]  cur_mode,
   input  wire        world_select_flag,
   input  wire        hyp_exc_entry,
   input  wire        xlat_write_perm,
   input  wire        xlat_exec_never_in,
   output wire        cp_ack,
   output wire        cp_undef,
   output reg  [31:0] cp_rdata,
   output wire        exception_instr_set_sel,
   output wire        hyp_exception_byte_order,
   output reg         exc_cpsr_e,
   output wire        walk_big_endian,
   output wire        xlat_exec_never,
   output wire        icache_en,
   output wire        dcache_en,
   output wire        align_check_en,
   output wire        stage1_xlat_en
);

   // synchronised reset copy
   reg         rst_meta_reg;
   reg         rst_sync_reg;
   wire        rst_int_b;

   // one flop per stored field; reserved positions keep no state
   reg         exc_iset_reg;
   reg         exc_iset_next;
   reg         byte_order_reg;
   reg         byte_order_next;
   reg         wr_no_exec_reg;
   reg         wr_no_exec_next;
   reg         icache_reg;
   reg         icache_next;
   reg         dcache_reg;
   reg         dcache_next;
   reg         align_reg;
   reg         align_next;
   reg         xlat_reg;
   reg         xlat_next;

   // next values of the read data and the captured exception byte order
   reg  [31:0] rdata_next;
   reg         exc_e_next;

   // selector decode and access strobes
   wire        sel_hit;
   wire        mode_ok;
   wire        req_live;
   wire        wr_strobe;
   wire        rd_strobe;
   wire        exc_strobe;
   wire [31:0] stored_word;

   // reset word of the writable fields
   localparam [31:0] RESET_WORD = `HSCR_RESET_VAL;

   // one field of a 32-bit word
   function field_bit;
      input [31:0]  word;
      input integer pos;
      begin
         field_bit = word[pos];
      end
   endfunction

   // stored fields placed at their positions, every other bit zero
   function [31:0] hscr_pack;
      input exc_iset;
      input byte_order;
      input wr_no_exec;
      input icache;
      input dcache;
      input align;
      input xlat;
      begin
         hscr_pack                        = 32'h00000000;
         hscr_pack[`HSCR_BIT_EXC_ISET]    = exc_iset;
         hscr_pack[`HSCR_BIT_BYTE_ORDER]  = byte_order;
         hscr_pack[`HSCR_BIT_LOW_LAT_IRQ] = 1'b0;
         hscr_pack[`HSCR_BIT_WR_NO_EXEC]  = wr_no_exec;
         hscr_pack[`HSCR_BIT_I]           = icache;
         hscr_pack[`HSCR_BIT_C]           = dcache;
         hscr_pack[`HSCR_BIT_A]           = align;
         hscr_pack[`HSCR_BIT_M]           = xlat;
      end
   endfunction

   // full register view: stored fields plus fixed reserved bits
   function [31:0] hscr_view;
      input [31:0] stored;
      begin
         hscr_view = (stored & `HSCR_WR_MASK) | `HSCR_RAO_MASK;
      end
   endfunction

   // reset release through two flip-flops
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_int_b = rst_sync_reg;

   hscr_access_check i_hscr_access_check (
      .cp_num            (cp_num),
      .cp_opc1           (cp_opc1),
      .cp_crn            (cp_crn),
      .cp_crm            (cp_crm),
      .cp_opc2           (cp_opc2),
      .cur_mode          (cur_mode),
      .world_select_flag (world_select_flag),
      .sel_hit           (sel_hit),
      .mode_ok           (mode_ok)
   );

   // handshake: accepted or refused in the request cycle
   assign req_live   = cp_valid && clk_en && sel_hit;
   assign cp_ack     = req_live && mode_ok;
   assign cp_undef   = req_live && !mode_ok;
   assign wr_strobe  = cp_ack && cp_write;
   assign rd_strobe  = cp_ack && !cp_write;
   assign exc_strobe = hyp_exc_entry && clk_en;

   // stored fields gathered into one word for the read path
   assign stored_word = hscr_pack(exc_iset_reg, byte_order_reg, wr_no_exec_reg, icache_reg,
                                  dcache_reg, align_reg, xlat_reg);

   // next field values: only an accepted write changes them
   always @* begin
      exc_iset_next   = exc_iset_reg;
      byte_order_next = byte_order_reg;
      wr_no_exec_next = wr_no_exec_reg;
      icache_next     = icache_reg;
      dcache_next     = dcache_reg;
      align_next      = align_reg;
      xlat_next       = xlat_reg;
      if (wr_strobe) begin
         exc_iset_next   = field_bit(cp_wdata, `HSCR_BIT_EXC_ISET);
         byte_order_next = field_bit(cp_wdata, `HSCR_BIT_BYTE_ORDER);
         wr_no_exec_next = field_bit(cp_wdata, `HSCR_BIT_WR_NO_EXEC);
         icache_next     = field_bit(cp_wdata, `HSCR_BIT_I);
         dcache_next     = field_bit(cp_wdata, `HSCR_BIT_C);
         align_next      = field_bit(cp_wdata, `HSCR_BIT_A);
         xlat_next       = field_bit(cp_wdata, `HSCR_BIT_M);
      end
   end

   // read data: register view as it stands before this edge
   always @* begin
      rdata_next = cp_rdata;
      if (rd_strobe) begin
         rdata_next = hscr_view(stored_word);
      end
   end

   // exception entry copies the current byte order into the status bit
   always @* begin
      exc_e_next = exc_cpsr_e;
      if (exc_strobe) begin
         exc_e_next = byte_order_reg;
      end
   end

   // field flops; reserved and unimplemented bits hold no state
   always @(posedge clk or negedge rst_int_b) begin
      if (!rst_int_b) begin
         exc_iset_reg   <= RESET_WORD[`HSCR_BIT_EXC_ISET];
         byte_order_reg <= RESET_WORD[`HSCR_BIT_BYTE_ORDER];
         wr_no_exec_reg <= RESET_WORD[`HSCR_BIT_WR_NO_EXEC];
         icache_reg     <= RESET_WORD[`HSCR_BIT_I];
         dcache_reg     <= RESET_WORD[`HSCR_BIT_C];
         align_reg      <= RESET_WORD[`HSCR_BIT_A];
         xlat_reg       <= RESET_WORD[`HSCR_BIT_M];
      end else if (clk_en) begin
         exc_iset_reg   <= exc_iset_next;
         byte_order_reg <= byte_order_next;
         wr_no_exec_reg <= wr_no_exec_next;
         icache_reg     <= icache_next;
         dcache_reg     <= dcache_next;
         align_reg      <= align_next;
         xlat_reg       <= xlat_next;
      end
   end

   // read data and captured exception byte order; frozen with the clock enable
   always @(posedge clk or negedge rst_int_b) begin
      if (!rst_int_b) begin
         cp_rdata   <= `HSCR_RDATA_RESET;
         exc_cpsr_e <= `HSCR_EXC_E_RESET;
      end else if (clk_en) begin
         cp_rdata   <= rdata_next;
         exc_cpsr_e <= exc_e_next;
      end
   end

   // control outputs steering the hypervisor context
   assign exception_instr_set_sel  = exc_iset_reg;
   assign hyp_exception_byte_order = byte_order_reg;
   assign walk_big_endian          = byte_order_reg;
   assign xlat_exec_never          = xlat_exec_never_in ||
                                     (wr_no_exec_reg && xlat_write_perm);
   assign icache_en                = icache_reg;
   assign dcache_en                = dcache_reg;
   assign align_check_en           = align_reg;
   assign stage1_xlat_en           = xlat_reg;

endmodule
`default_nettype wire

//--- test/hscr_properties.sv
// hscr_properties.sv: assertions on the ports of hscr_top
// assumes: bound onto hscr_top, one clock, rst_b active low
`timescale 1ns/100ps
`default_nettype none
module hscr_properties (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        cp_ack,
   input wire logic        cp_undef,
   input wire logic        cp_write,
   input wire logic [31:0] cp_wdata,
   input wire logic [4:0]  cur_mode,
   input wire logic        world_select_flag,
   input wire logic [31:0] cp_rdata,
   input wire logic        exception_instr_set_sel,
   input wire logic        hyp_exception_byte_order,
   input wire logic        walk_big_endian,
   input wire logic        icache_en,
   input wire logic        dcache_en,
   input wire logic        align_check_en,
   input wire logic        stage1_xlat_en,
   input wire logic        clk_en,
   input wire logic        hyp_exc_entry,
   input wire logic        exc_cpsr_e,
   input wire logic        xlat_write_perm,
   input wire logic        xlat_exec_never_in,
   input wire logic        xlat_exec_never
);
   // accepted write, accepted read and permitted mode
   wire logic wr = cp_ack && cp_write;
   wire logic rd = cp_ack && !cp_write;
   wire logic ok = cur_mode == 5'h1A || (cur_mode == 5'h16 && world_select_flag);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // control outputs, and the stored fields as a read returns them
   wire logic [6:0] ctl = {exception_instr_set_sel, hyp_exception_byte_order, walk_big_endian, icache_en,
                           dcache_en, align_check_en, stage1_xlat_en};
   wire logic [7:0] rd_fields = {cp_rdata[30], cp_rdata[25], cp_rdata[25], cp_rdata[19], cp_rdata[12],
                                 cp_rdata[2:0]};
   // write-forces-no-exec bit as last written; no port shows it directly
   logic no_exec_model;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) no_exec_model <= 1'b0;
      else if (wr) no_exec_model <= cp_wdata[19];
   end
   ack_mode_a: assert property (cp_ack |-> ok) else $error("ack in barred mode");
   undef_mode_a: assert property (cp_undef |-> !ok) else $error("undef in allowed mode");
   undef_hold_a: assert property (cp_undef |=> ctl == $past(ctl))
      else $error("refused access changed controls");
   readback_a: assert property (rd |=> rd_fields == {ctl[6:4], no_exec_model, ctl[3:0]})
      else $error("read data fields bad");
   exc_iset_upd_a: assert property (wr |=> exception_instr_set_sel == $past(cp_wdata[30]))
      else $error("instruction set select bad");
   exc_order_a: assert property (hyp_exc_entry && clk_en |=> exc_cpsr_e == $past(hyp_exception_byte_order))
      else $error("captured byte order bad");
   order_upd_a: assert property (
      wr |=> {walk_big_endian, hyp_exception_byte_order} == {2{$past(cp_wdata[25])}})
      else $error("byte order bad");
   xn_force_a: assert property (
      xlat_exec_never == (xlat_exec_never_in || (no_exec_model && xlat_write_perm)))
      else $error("execute never bad");
   icache_upd_a: assert property (wr |=> icache_en == $past(cp_wdata[12])) else $error("icache bad");
   dcache_upd_a: assert property (wr |=> dcache_en == $past(cp_wdata[2])) else $error("dcache bad");
   low_ctl_a: assert property (wr |=> {align_check_en, stage1_xlat_en} == $past(cp_wdata[1:0]))
      else $error("align or xlat bad");
   fixed_bits_a: assert property (rd |=> (cp_rdata & 32'hBDF7EFF8) == 32'h30C50878)
      else $error("fixed bits bad");
endmodule
bind hscr_top hscr_properties i_hscr_properties (
   .clk                      (clk),
   .rst_b                    (rst_b),
   .cp_ack                   (cp_ack),
   .cp_undef                 (cp_undef),
   .cp_write                 (cp_write),
   .cp_wdata                 (cp_wdata),
   .cur_mode                 (cur_mode),
   .world_select_flag        (world_select_flag),
   .cp_rdata                 (cp_rdata),
   .exception_instr_set_sel  (exception_instr_set_sel),
   .hyp_exception_byte_order (hyp_exception_byte_order),
   .walk_big_endian          (walk_big_endian),
   .icache_en                (icache_en),
   .dcache_en                (dcache_en),
   .align_check_en           (align_check_en),
   .stage1_xlat_en           (stage1_xlat_en),
   .clk_en                   (clk_en),
   .hyp_exc_entry            (hyp_exc_entry),
   .exc_cpsr_e               (exc_cpsr_e),
   .xlat_write_perm          (xlat_write_perm),
   .xlat_exec_never_in       (xlat_exec_never_in),
   .xlat_exec_never          (xlat_exec_never)
);
`default_nettype wire

//--- test/hyp_system_control_reg_tb_top.sv
// hyp_system_control_reg_tb_top.sv: self-checking bench for hscr_top
// assumes: 50 ns clock, inputs driven on the falling edge
`timescale 1ns/100ps
`default_nettype none
module hyp_system_control_reg_tb_top;
   logic        clk = 0, rst_b = 0, clk_en = 1, cp_valid = 0, cp_write = 0, world_select_flag = 0;
   logic        hyp_exc_entry = 0, xlat_write_perm = 1, xlat_exec_never_in = 0;
   logic [3:0]  cp_num = 4'hF, cp_crn = 4'h1, cp_crm = 4'h0;
   logic [2:0]  cp_opc1 = 3'h4, cp_opc2 = 3'h0;
   logic [31:0] cp_wdata = 32'h0;
   logic [4:0]  cur_mode = 5'h1A;
   wire logic   cp_ack, cp_undef, exception_instr_set_sel, hyp_exception_byte_order, exc_cpsr_e, walk_big_endian;
   wire logic   xlat_exec_never, icache_en, dcache_en, align_check_en, stage1_xlat_en;
   wire logic [31:0] cp_rdata;
   wire logic [6:0]  outs = {exception_instr_set_sel, hyp_exception_byte_order, walk_big_endian, icache_en,
                             dcache_en, align_check_en, stage1_xlat_en};
   int          mismatches = 0, tests_run = 0;
   hscr_top i_hscr_top (
      .clk                      (clk),
      .rst_b                    (rst_b),
      .clk_en                   (clk_en),
      .cp_valid                 (cp_valid),
      .cp_write                 (cp_write),
      .cp_num                   (cp_num),
      .cp_opc1                  (cp_opc1),
      .cp_crn                   (cp_crn),
      .cp_crm                   (cp_crm),
      .cp_opc2                  (cp_opc2),
      .cp_wdata                 (cp_wdata),
      .cur_mode                 (cur_mode),
      .world_select_flag        (world_select_flag),
      .hyp_exc_entry            (hyp_exc_entry),
      .xlat_write_perm          (xlat_write_perm),
      .xlat_exec_never_in       (xlat_exec_never_in),
      .cp_ack                   (cp_ack),
      .cp_undef                 (cp_undef),
      .cp_rdata                 (cp_rdata),
      .exception_instr_set_sel  (exception_instr_set_sel),
      .hyp_exception_byte_order (hyp_exception_byte_order),
      .exc_cpsr_e               (exc_cpsr_e),
      .walk_big_endian          (walk_big_endian),
      .xlat_exec_never          (xlat_exec_never),
      .icache_en                (icache_en),
      .dcache_en                (dcache_en),
      .align_check_en           (align_check_en),
      .stage1_xlat_en           (stage1_xlat_en)
   );
   // free-running clock
   initial begin
      forever #25 clk = ~clk;
   end
   task chk(input string n, input logic [31:0] e, s);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // one transfer, ack and undef looked at while held
   task xfer(input logic w, input logic [31:0] d, input logic [4:0] m, input logic f, input logic [1:0] e);
      @(negedge clk);
      {cp_valid, cp_write, cp_wdata, cur_mode, world_select_flag} = {1'b1, w, d, m, f};
      #1 chk("ack_undef", {30'h0, e}, {30'h0, cp_ack, cp_undef});
      @(negedge clk);
      cp_valid = 1'b0;
   endtask
   task wr(input logic [31:0] d, input logic [4:0] m, input logic f);
      xfer(1'b1, d, m, f, 2'b10);
      chk("ctl", {25'h0, d[30], d[25], d[25], d[12], d[2], d[1], d[0]}, {25'h0, outs});
   endtask
   task rd(input logic [31:0] e);
      xfer(1'b0, 32'h0, 5'h1A, 1'b0, 2'b10);
      chk("rdata", e, cp_rdata);
   endtask
   // pulse an exception entry and check the captured endianness
   task ent(input logic e);
      @(negedge clk);
      hyp_exc_entry = 1'b1;
      @(negedge clk);
      hyp_exc_entry = 1'b0;
      chk("exc_e", {31'h0, e}, {31'h0, exc_cpsr_e});
   endtask
   task complete_run;
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      rd(32'h30C50878);
      wr(32'hFFFFFFFF, 5'h1A, 1'b0);
      rd(32'h72CD187F);
      chk("xn", 32'h1, {31'h0, xlat_exec_never});
      ent(1'b1);
      xfer(1'b1, 32'h0, 5'h16, 1'b0, 2'b01);
      xfer(1'b1, 32'h0, 5'h13, 1'b1, 2'b01);
      cp_crn = 4'h2;
      xfer(1'b1, 32'h0, 5'h1A, 1'b0, 2'b00);
      {cp_crn, cp_opc1} = {4'h1, 3'h0};
      xfer(1'b1, 32'h0, 5'h1A, 1'b0, 2'b00);
      cp_opc1 = 3'h4;
      clk_en = 1'b0;
      xfer(1'b1, 32'h0, 5'h1A, 1'b0, 2'b00);
      clk_en = 1'b1;
      chk("ctl", 32'h7F, {25'h0, outs});
      wr(32'h02080000, 5'h16, 1'b1);
      rd(32'h32CD0878);
      xlat_write_perm = 1'b0;
      #1 chk("xn", 32'h0, {31'h0, xlat_exec_never});
      ent(1'b1);
      wr(32'h0, 5'h1A, 1'b0);
      xlat_write_perm = 1'b1;
      #1 chk("xn", 32'h0, {31'h0, xlat_exec_never});
      xlat_exec_never_in = 1'b1;
      #1 chk("xn", 32'h1, {31'h0, xlat_exec_never});
      ent(1'b0);
      complete_run;
   end
endmodule
`default_nettype wire
